/* File: rtl/oam_exec.sv */
`timescale 1ns/1ps
module oam_exec #(
    parameter int INSTR_W = oam_pkg::INSTR_W,
    parameter int DATA_W  = oam_pkg::DATA_W,
    parameter int ADDR_W  = oam_pkg::ADDR_W
) (
    // Clock and reset.
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Instruction from fetch, one per instruction-cycle enable.
    input  wire logic               instr_valid,
    input  wire logic [INSTR_W-1:0] instr_word,
    // File register read data for the address on file_raddr.
    input  wire logic [DATA_W-1:0]  file_rdata,
    output logic      [ADDR_W-1:0]  file_raddr,
    // File register write port.
    output logic                    file_we,
    output logic      [ADDR_W-1:0]  file_waddr,
    output logic      [DATA_W-1:0]  file_wdata,
    // Core state.
    output logic      [DATA_W-1:0]  acc,
    output logic                    zero_flag,
    output logic                    zero_flag_we,
    output logic                    instr_done
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic oam_pkg::oam_op_t decode_op(
        input logic [INSTR_W-1:0] w
    );
        logic [5:0] top;
        top = w[oam_pkg::OPC_HI:oam_pkg::OPC_LO];
        decode_op = oam_pkg::OAM_OP_NONE;
        if (top == oam_pkg::OPC_OR_LIT)
            decode_op = oam_pkg::OAM_OP_OR_LIT;
        else if (top == oam_pkg::OPC_OR_FILE)
            decode_op = oam_pkg::OAM_OP_OR_FILE;
        else if (top == oam_pkg::OPC_MOVE_FILE)
            decode_op = oam_pkg::OAM_OP_MOVE_FILE;
        else if (top[5:2] == oam_pkg::OPC_LOAD_LIT)
            decode_op = oam_pkg::OAM_OP_LOAD_LIT;
        else if (top == oam_pkg::OPC_STORE && w[oam_pkg::DEST_BIT])
            decode_op = oam_pkg::OAM_OP_STORE;
    endfunction

    // Zero test shared by every instruction that updates the flag.
    function automatic logic is_zero(
        input logic [DATA_W-1:0] v
    );
        is_zero = (v == '0);
    endfunction

    oam_pkg::oam_op_t       op;
    logic [DATA_W-1:0]      literal;
    logic [ADDR_W-1:0]      faddr;
    logic                   dest_file;

    // The file address is combinational so the register file answers in
    // the same cycle; this keeps every instruction to one cycle.
    assign op         = decode_op(instr_word);
    assign literal    = instr_word[DATA_W-1:0];
    assign faddr      = instr_word[ADDR_W-1:0];
    assign dest_file  = instr_word[oam_pkg::DEST_BIT];
    assign file_raddr = faddr;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] acc_ff,    nxt_acc;
    logic              zf_ff,     nxt_zf;
    logic              zfwe_ff,   nxt_zfwe;
    logic              done_ff,   nxt_done;
    logic              we_ff,     nxt_we;
    logic [ADDR_W-1:0] waddr_ff,  nxt_waddr;
    logic [DATA_W-1:0] wdata_ff,  nxt_wdata;
    logic [DATA_W-1:0] result;

    // ------------------------------------------------------------------
    // Result
    // ------------------------------------------------------------------
    // One result path feeds both the accumulator and the write port; each
    // instruction loads the accumulator or the write port registers, never both.
    always_comb begin
        result = '0;
        case (op)
            oam_pkg::OAM_OP_OR_LIT: begin
                result = acc_ff | literal;
            end
            oam_pkg::OAM_OP_OR_FILE: begin
                result = acc_ff | file_rdata;
            end
            oam_pkg::OAM_OP_MOVE_FILE: begin
                result = file_rdata;
            end
            oam_pkg::OAM_OP_LOAD_LIT: begin
                result = literal;
            end
            oam_pkg::OAM_OP_STORE: begin
                result = acc_ff;
            end
            default: begin
                result = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Accumulator, zero flag and completion
    // ------------------------------------------------------------------
    always_comb begin
        nxt_acc  = acc_ff;
        nxt_zf   = zf_ff;
        nxt_zfwe = 1'b0;
        nxt_done = 1'b0;
        if (instr_valid) begin
            case (op)
                oam_pkg::OAM_OP_OR_LIT: begin
                    nxt_acc  = result;
                    nxt_zf   = is_zero(result);
                    nxt_zfwe = 1'b1;
                    nxt_done = 1'b1;
                end
                oam_pkg::OAM_OP_OR_FILE,
                oam_pkg::OAM_OP_MOVE_FILE: begin
                    if (!dest_file) begin
                        nxt_acc = result;
                    end
                    // The flag follows the result for both destinations,
                    // which lets a move back into place test a register.
                    nxt_zf   = is_zero(result);
                    nxt_zfwe = 1'b1;
                    nxt_done = 1'b1;
                end
                oam_pkg::OAM_OP_LOAD_LIT: begin
                    nxt_acc  = result;
                    nxt_done = 1'b1;
                end
                oam_pkg::OAM_OP_STORE: begin
                    nxt_done = 1'b1;
                end
                default: begin
                    nxt_done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            acc_ff  <= oam_pkg::ACC_RESET;
            zf_ff   <= 1'b0;
            zfwe_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            acc_ff  <= nxt_acc;
            zf_ff   <= nxt_zf;
            zfwe_ff <= nxt_zfwe;
            done_ff <= nxt_done;
        end
    end

    // ------------------------------------------------------------------
    // File write port
    // ------------------------------------------------------------------
    // Address and data hold after the strobe so a slow file can take
    // them late; only the strobe itself is a one-cycle pulse.
    always_comb begin
        nxt_we    = 1'b0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        if (instr_valid) begin
            case (op)
                oam_pkg::OAM_OP_OR_FILE,
                oam_pkg::OAM_OP_MOVE_FILE: begin
                    if (dest_file) begin
                        nxt_we    = 1'b1;
                        nxt_waddr = faddr;
                        nxt_wdata = result;
                    end
                end
                oam_pkg::OAM_OP_STORE: begin
                    nxt_we    = 1'b1;
                    nxt_waddr = faddr;
                    nxt_wdata = result;
                end
                default: begin
                    nxt_we = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            we_ff    <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
        end else begin
            we_ff    <= nxt_we;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign acc          = acc_ff;
    assign zero_flag    = zf_ff;
    assign zero_flag_we = zfwe_ff;
    assign file_we      = we_ff;
    assign file_waddr   = waddr_ff;
    assign file_wdata   = wdata_ff;
    assign instr_done   = done_ff;

endmodule

/* File: shared/oam_pkg.sv */
package oam_pkg;

    // ------------------------------------------------------------------
    // Instruction word layout
    // ------------------------------------------------------------------
    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int OPC_HI    = 13;
    localparam int OPC_LO    = 8;
    localparam int DEST_BIT  = 7;

    // Top six bits of each instruction.
    localparam logic [5:0] OPC_OR_LIT    = 6'h38;
    localparam logic [5:0] OPC_OR_FILE   = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
    localparam logic [5:0] OPC_STORE     = 6'h00;
    // Literal load matches on the top four bits only.
    localparam logic [3:0] OPC_LOAD_LIT  = 4'hC;

    localparam logic [7:0] ACC_RESET     = 8'h00;

    typedef enum logic [2:0] {
        OAM_OP_NONE,
        OAM_OP_OR_LIT,
        OAM_OP_OR_FILE,
        OAM_OP_MOVE_FILE,
        OAM_OP_LOAD_LIT,
        OAM_OP_STORE
    } oam_op_t;

endpackage

/* File: verif/oam_exec_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// Execute checks; file data is judged as seen at the issue edge.
// ----------------------------------------------------------
module oam_exec_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0]  file_rdata,
    input wire logic [6:0]  file_raddr,
    input wire logic        file_we,
    input wire logic [6:0]  file_waddr,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic        zero_flag,
    input wire logic        zero_flag_we,
    input wire logic        instr_done
);
    logic       v;
    logic [5:0] op;
    logic       d;
    assign v  = instr_valid;
    assign op = instr_word[13:8];
    assign d  = instr_word[7];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    or_lit_a: assert property (
        v && op == 6'h38 |=>
        acc == ($past(acc) | $past(instr_word[7:0])))
        else $error("literal or result");
    lit_zero_a: assert property (
        v && op == 6'h38 |=>
        zero_flag_we && !file_we && zero_flag == (acc == 8'h00))
        else $error("literal or zero flag");
    or_file_a: assert property (
        v && op == 6'h04 && !d |=> zero_flag_we && !file_we &&
        acc == ($past(acc) | $past(file_rdata)) &&
        zero_flag == (acc == 8'h00))
        else $error("file or result");
    or_dest_a: assert property (
        v && op == 6'h04 && d |=> file_we &&
        file_waddr == $past(instr_word[6:0]) &&
        file_wdata == ($past(acc) | $past(file_rdata)) && $stable(acc))
        else $error("file or destination");
    move_acc_a: assert property (
        v && op == 6'h08 && !d |=> !file_we &&
        acc == $past(file_rdata))
        else $error("move to accumulator");
    move_zero_a: assert property (
        v && op == 6'h08 |=> zero_flag_we &&
        zero_flag == ($past(file_rdata) == 8'h00))
        else $error("move zero flag");
    load_lit_a: assert property (
        v && op[5:2] == 4'hC |=> acc == $past(instr_word[7:0]) &&
        !zero_flag_we && $stable(zero_flag))
        else $error("literal load");
    store_acc_a: assert property (
        v && op == 6'h00 && d |=> file_we &&
        file_wdata == $past(acc) && file_waddr == $past(instr_word[6:0])
        && !zero_flag_we && $stable(acc))
        else $error("store");
    raddr_map_a: assert property (
        file_raddr == instr_word[6:0])
        else $error("read address");
    done_pulse_a: assert property (
        v && (op == 6'h38 || op == 6'h04 || op == 6'h08 ||
        op[5:2] == 4'hC || (op == 6'h00 && d)) |=> instr_done)
        else $error("done pulse");
    refused_op_a: assert property (
        v && op == 6'h00 && !d |=> !instr_done && !file_we &&
        !zero_flag_we && $stable(acc))
        else $error("refused opcode");
    cover property (v && op == 6'h04 && d);
    cover property (v && op == 6'h08 && d);
    cover property (v && op[5:2] == 4'hC);
    cover property (v && op == 6'h00 && d);
endmodule
bind oam_exec oam_exec_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rdata(file_rdata), .file_raddr(file_raddr), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc),
    .zero_flag(zero_flag), .zero_flag_we(zero_flag_we),
    .instr_done(instr_done));

/* File: verif/oam_exec_bench.sv */
`timescale 1ns/1ps
module oam_exec_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0]  file_rdata, file_wdata, acc;
    logic [6:0]  file_raddr, file_waddr;
    logic        file_we, zero_flag, zero_flag_we, instr_done;
    logic [7:0]  mem [128];
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    oam_exec u_oam_exec (.sys_clk(sys_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .file_rdata(file_rdata), .file_raddr(file_raddr), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc),
        .zero_flag(zero_flag), .zero_flag_we(zero_flag_we),
        .instr_done(instr_done));
    // ----------------------------------------------------------
    // File model: commits on the strobe edge so the next read sees it.
    // ----------------------------------------------------------
    assign file_rdata = mem[file_raddr];
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (file_we === 1'b1) begin
            mem[file_waddr] <= file_wdata;
        end
        if (cycles == 1000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t output mismatch", $time);
        end
    endtask
    task automatic ex(input logic [13:0] w);
        @(posedge sys_clk);
        #1 instr_valid = 1'b1;
        instr_word = w;
        @(posedge sys_clk);
        #1 instr_valid = 1'b0;
    endtask
    task automatic t_or_lit();
        ex(14'h309A);
        ex(14'h3835);
        chk(acc === 8'hBF);
        chk(zero_flag === 1'b0 && zero_flag_we === 1'b1);
        chk(file_we === 1'b0 && instr_done === 1'b1);
        ex(14'h3000);
        ex(14'h3800);
        chk(zero_flag === 1'b1 && instr_done === 1'b1);
    endtask
    task automatic t_load();
        for (int i = 0; i < 4; i++) begin
            ex({4'hC, i[1:0], 8'h5A ^ i[7:0]});
            chk(acc === (8'h5A ^ i[7:0]));
            chk(zero_flag === 1'b1 && zero_flag_we === 1'b0);
        end
    endtask
    task automatic t_or_file();
        ex(14'h3091);
        ex(14'h0413);
        chk(acc === 8'h93 && file_we === 1'b0);
        chk(zero_flag === 1'b0 && zero_flag_we === 1'b1);
        ex(14'h0485);
        chk(file_we === 1'b1 && file_waddr === 7'h05);
        chk(file_wdata === 8'h97 && acc === 8'h93);
        chk(file_raddr === 7'h05);
    endtask
    task automatic t_move();
        ex(14'h0800);
        chk(acc === 8'h00 && zero_flag === 1'b1);
        ex(14'h0885);
        chk(zero_flag === 1'b0 && zero_flag_we === 1'b1);
        chk(file_we === 1'b1 && file_wdata === 8'h97);
        chk(acc === 8'h00);
    endtask
    task automatic t_store();
        ex(14'h304F);
        ex(14'h00A5);
        chk(file_we === 1'b1 && file_waddr === 7'h25);
        chk(file_wdata === 8'h4F && zero_flag_we === 1'b0);
        ex(14'h0025);
        chk(instr_done === 1'b0 && file_we === 1'b0);
        ex(14'h3000);
        ex(14'h0825);
        chk(acc === 8'h4F);
    endtask
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = i[7:0];
        end
        repeat (12) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 chk(acc === 8'h00 && zero_flag === 1'b0 && file_we === 1'b0);
        t_or_lit();
        t_load();
        t_or_file();
        t_move();
        t_store();
        stop_test();
    end
endmodule
